// ### logic/phy_status_consts.vh
`ifndef PHY_STATUS_CONSTS_VH
`define PHY_STATUS_CONSTS_VH

// management register addresses
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_ID1 5'h02
`define REG_ID2 5'h03
`define REG_ADV 5'h04
`define REG_EXT 5'h0f

// management frame opcodes
`define OP_WR 2'h1
`define OP_RD 2'h2

// frame field lengths, as last-bit counter values
`define HDR_LAST 4'hb
`define TA_LAST 4'h1
`define DATA_LAST 4'hf

// header field positions in the receive shifter, taken at the last header bit
`define HDR_OP_HI 10
`define HDR_OP_LO 9
`define HDR_PA_HI 8
`define HDR_PA_LO 4
`define HDR_RA_HI 3

// status word: fixed ability bits 14..11, 8, 6, 3, 0 set
`define STAT_FIXED 16'h7949
`define ST_ANC 5
`define ST_RFLT 4
`define ST_LINK 2
`define ST_JAB 1

// control word layout
`define CTRL_RST 15
`define CTRL_RESTART 9
`define CTRL_WR_MASK 16'h7dc0
`define CTRL_DEFAULT 16'h1140

// advertisement layout: bits 14, 12 and 9 read as zero
`define ADV_WR_MASK 16'hadff
`define ADV_DEFAULT 16'h01e1

// identifier field positions
`define ID2_OUI_HI 15
`define ID2_OUI_LO 10
`define ID2_MDL_HI 9
`define ID2_MDL_LO 4
`define ID2_REV_HI 3
`define ID2_REV_LO 0

// soft reset duration
`define CLK_PERIOD_NS 5
`define SRST_TIME_NS 100

`endif

// ### logic/phy_status_regs.v
`include "phy_status_consts.vh"

module phy_status_regs #(
    parameter [4:0] PHY_ADDR = 5'h01,   // management address of this device
    parameter [15:0] OUI_WORD1 = 16'h2a5c, // arbitrary value
    parameter [5:0] OUI_WORD2 = 6'h15,  // arbitrary value
    parameter [5:0] MODEL_CODE = 6'h2b, // arbitrary value
    parameter [3:0] REV_CODE = 4'h7,    // arbitrary value
    parameter [15:0] EXT_STATUS = 16'h0000 // extended status content
) (
    input wire sys_clk_in,              // system clock, 200 MHz
    input wire sys_rst_in,              // async reset, active high
    input wire mdc_in,                  // management clock pin
    input wire mdio_in,                 // management data pin, input side
    output wire mdio_out,               // management data pin, output side
    output wire mdio_oe_out,            // management data drive enable
    input wire an_done_in,              // negotiation complete, level
    input wire remote_fault_in,         // remote fault seen, level
    input wire link_ok_in,              // valid link, level
    input wire jabber_in,               // jabber seen, level
    output wire an_restart_out,         // restart negotiation, one-cycle pulse
    output wire soft_reset_out,         // soft reset in progress, level
    output wire [15:0] ctrl_word_out,   // stored control bits
    output wire [15:0] adv_word_out     // stored advertisement bits
);

    // frame engine states, binary coded
    localparam [2:0] ST_IDLE = 3'h0;    // waiting for start bits
    localparam [2:0] ST_HDR = 3'h1;     // opcode, addresses
    localparam [2:0] ST_TA = 3'h2;      // turnaround
    localparam [2:0] ST_DATA = 3'h3;    // sixteen data bits

    // rounded up so the reset is never shorter than asked
    // the count must fit the eight-bit countdown below, so keep the reset time short
    localparam integer SRST_CYC_FULL = (`SRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [7:0] SRST_CYC = SRST_CYC_FULL[7:0];

    // synchronisers and frame engine
    reg mdc_s1_r, mdc_s2_r, mdc_s3_r;  // mdc synchroniser and edge stage
    reg mdio_s1_r, mdio_s2_r;           // mdio synchroniser
    reg [2:0] state_r;                  // frame state
    reg [3:0] cnt_r;                    // bit counter in field
    reg prev_r;                         // previous idle bit
    reg [15:0] sh_r;                    // receive shifter
    reg [15:0] rd_sh_r;                 // transmit shifter
    reg [4:0] reg_r;                    // addressed register
    reg is_rd_r, is_wr_r;               // frame addressed to us
    reg mdio_out_r, mdio_oe_r;          // pin drive
    // stored words, flags and soft reset
    reg [15:0] ctrl_r;                  // control storage
    reg [15:0] adv_r;                   // advertisement storage
    reg rflt_r, link_r, jab_r;          // latched status flags
    wire stat_rd_now;                   // status snapshot and latch clear on this edge
    reg restart_r;                      // restart pulse
    reg busy_r;                         // soft reset running
    reg [7:0] srst_cnt_r;               // soft reset countdown
    reg wr_ctrl_r, wr_adv_r;            // write commit strobes
    reg [15:0] wr_data_r;               // committed write data
    // combinational images
    reg [15:0] stat_word;               // live status image
    reg [15:0] rd_word;                 // read mux result
    wire mdc_rise;                      // sampled rising edge of mdc
    wire bit_in;                        // data bit taken at that edge

    assign mdc_rise = mdc_s2_r & ~mdc_s3_r;
    assign bit_in = mdio_s2_r;

    // status read: the snapshot and the clear share one edge, so an event
    // that lands one cycle after the snapshot can never be wiped unseen
    assign stat_rd_now = mdc_rise & is_rd_r & (state_r == ST_TA) & (cnt_r != `TA_LAST) &
                         (reg_r == `REG_STAT);

    // true when the header carries the given opcode and this device's address
    function op_for_us;
        input [`HDR_OP_HI:0] hdr;       // opcode, device address, upper register bits
        input [1:0] op;                 // opcode looked for
        begin
            op_for_us = (hdr[`HDR_OP_HI:`HDR_OP_LO] == op) && (hdr[`HDR_PA_HI:`HDR_PA_LO] == PHY_ADDR);
        end
    endfunction

    // two-flop synchronisers; edge detect looks only at stages two and three
    // both pins reset to their idle levels, so no false edge or start follows reset
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
        end else begin
            mdc_s1_r <= mdc_in;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= mdio_in;
            mdio_s2_r <= mdio_s1_r;
        end
    end

    // status image built from fixed abilities, the live negotiation bit and latched flags
    // bit 2 reads low after reset until a status read refreshes it
    always @* begin
        stat_word = `STAT_FIXED;
        stat_word[`ST_ANC] = an_done_in;
        stat_word[`ST_RFLT] = rflt_r;
        stat_word[`ST_LINK] = link_r;
        stat_word[`ST_JAB] = jab_r;
    end

    // read mux; unmapped addresses return zero
    // reg_r only changes at a header's end, so the snapshot sees a settled word
    always @* begin
        rd_word = 16'h0000;
        case (reg_r)
            `REG_CTRL: begin
                rd_word = ctrl_r;
                rd_word[`CTRL_RST] = busy_r;
            end
            `REG_STAT: rd_word = stat_word;
            // identifier fields come from parameters and are never writable
            `REG_ID1: rd_word = OUI_WORD1;
            `REG_ID2: begin
                rd_word[`ID2_OUI_HI:`ID2_OUI_LO] = OUI_WORD2;
                rd_word[`ID2_MDL_HI:`ID2_MDL_LO] = MODEL_CODE;
                rd_word[`ID2_REV_HI:`ID2_REV_LO] = REV_CODE;
            end
            `REG_ADV: rd_word = adv_r;
            `REG_EXT: rd_word = EXT_STATUS;
            default: rd_word = 16'h0000;
        endcase
    end

    // management frame engine; start is a 0 then 1 after idle ones, so no preamble is needed
    // cnt_r counts bits within a field and restarts at each new field
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            prev_r <= 1'b1;
            sh_r <= 16'h0000;
            rd_sh_r <= 16'h0000;
            reg_r <= 5'h00;
            is_rd_r <= 1'b0;
            is_wr_r <= 1'b0;
            mdio_out_r <= 1'b1;
            mdio_oe_r <= 1'b0;
            wr_ctrl_r <= 1'b0;
            wr_adv_r <= 1'b0;
            wr_data_r <= 16'h0000;
        end else begin
            wr_ctrl_r <= 1'b0;
            wr_adv_r <= 1'b0;
            if (mdc_rise) begin
                case (state_r)
                    // idle: hunt for a 0 then 1; any run of ones before it is preamble
                    ST_IDLE: begin
                        prev_r <= bit_in;
                        if (!prev_r && bit_in) begin
                            state_r <= ST_HDR;
                            cnt_r <= 4'h0;
                        end
                    end
                    // header: twelve bits, decoded on the last one
                    ST_HDR: begin
                        sh_r <= {sh_r[14:0], bit_in};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `HDR_LAST) begin
                            // header is op[11:10] phy[9:5] reg[4:0]
                            reg_r <= {sh_r[`HDR_RA_HI:0], bit_in};
                            is_rd_r <= op_for_us(sh_r[`HDR_OP_HI:0], `OP_RD);
                            is_wr_r <= op_for_us(sh_r[`HDR_OP_HI:0], `OP_WR);
                            cnt_r <= 4'h0;
                            state_r <= ST_TA;
                        end
                    end
                    // turnaround: the line changes hands after the first bit
                    ST_TA: begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r != `TA_LAST) begin
                            if (is_rd_r) begin
                                // latches clear on this same edge, see stat_rd_now
                                rd_sh_r <= rd_word;
                                mdio_oe_r <= 1'b1;
                                mdio_out_r <= 1'b0;
                            end
                        end else begin
                            // second bit: the first data bit goes out
                            if (is_rd_r) begin
                                mdio_out_r <= rd_sh_r[15];
                                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
                            end
                            cnt_r <= 4'h0;
                            state_r <= ST_DATA;
                        end
                    end
                    // data: shift in for writes, shift out for reads
                    ST_DATA: begin
                        sh_r <= {sh_r[14:0], bit_in};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `DATA_LAST) begin
                            // bit 0 is out: release at once so the station has the line back
                            mdio_oe_r <= 1'b0;
                            mdio_out_r <= 1'b1;
                            wr_data_r <= {sh_r[14:0], bit_in};
                            wr_ctrl_r <= is_wr_r && (reg_r == `REG_CTRL);
                            wr_adv_r <= is_wr_r && (reg_r == `REG_ADV);
                            prev_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (is_rd_r) begin
                            mdio_out_r <= rd_sh_r[15];
                            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // control, advertisement and soft reset; writes during soft reset are dropped
    // the soft reset runs for a fixed time, not a fixed number of link clocks
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_r <= `CTRL_DEFAULT;
            adv_r <= `ADV_DEFAULT;
            busy_r <= 1'b0;
            srst_cnt_r <= 8'h00;
            restart_r <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            // soft reset holds both words at their defaults
            if (busy_r) begin
                ctrl_r <= `CTRL_DEFAULT;
                adv_r <= `ADV_DEFAULT;
                srst_cnt_r <= srst_cnt_r - 8'h01;
                if (srst_cnt_r == 8'h01) begin
                    busy_r <= 1'b0;
                end
            end else if (wr_ctrl_r) begin
                if (wr_data_r[`CTRL_RST]) begin
                    busy_r <= 1'b1;
                    srst_cnt_r <= SRST_CYC;
                end else begin
                    // bit 9 is not stored: it only pulses the restart
                    ctrl_r <= wr_data_r & `CTRL_WR_MASK;
                    restart_r <= wr_data_r[`CTRL_RESTART];
                end
            end else if (wr_adv_r) begin
                // only software writes reach this register
                adv_r <= wr_data_r & `ADV_WR_MASK;
                restart_r <= ~an_done_in;
            end
        end
    end

    // latched flags: a new event in the clearing cycle wins over the clear
    // fault and jabber latch high, link latches low; the read snapshot and
    // the clear share one edge, so no one-cycle event falls between them
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rflt_r <= 1'b0;
            link_r <= 1'b0;
            jab_r <= 1'b0;
        end else if (busy_r) begin
            rflt_r <= 1'b0;
            link_r <= 1'b0;
            jab_r <= 1'b0;
        end else begin
            rflt_r <= remote_fault_in | (rflt_r & ~stat_rd_now);
            link_r <= link_ok_in & (link_r | stat_rd_now);
            jab_r <= jabber_in | (jab_r & ~stat_rd_now);
        end
    end

    // outputs are the flops themselves, no logic after them
    assign mdio_out = mdio_out_r;
    assign mdio_oe_out = mdio_oe_r;
    assign an_restart_out = restart_r;
    assign soft_reset_out = busy_r;
    assign ctrl_word_out = ctrl_r;
    assign adv_word_out = adv_r;

endmodule // phy_status_regs

// ### sim/mgmt_station.sv
// management station: makes the link clock only inside frames
module mgmt_station (
    output logic mdc_out,      // link clock, still between frames
    output logic drv_out,      // data we put on the line
    output logic oe_out,       // high while we drive the line
    input wire logic mdio_in   // resolved line level
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc_out = 1'b0;
        drv_out = 1'b1;
        oe_out = 1'b0;
    end
    // data changes while the clock is low, sampled at the rise
    task automatic slot(input logic b, output logic s);
        drv_out = b;
        #32 mdc_out = 1'b1;
        s = mdio_in;
        #32 mdc_out = 1'b0;
    endtask
    // one frame; pre adds a full preamble, otherwise a single idle bit
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] w;
        logic s;
        w = {2'b01, op, pa, ra, 2'b10, wd};
        oe_out = 1'b1;
        repeat (pre ? 32 : 1) slot(1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            if (op == 2'b10 && i == 17) oe_out = 1'b0; // hand the line over for the turnaround
            slot(w[i], s);
            if (i < 16) rd[i] = s;
        end
        oe_out = 1'b0;
        drv_out = 1'b1;
    endtask
endmodule // mgmt_station

// ### sim/phy_status_regs_checker.sv
// watches the register block at its pins only
module phy_status_regs_checker (
    input wire logic sys_clk_in,          // system clock
    input wire logic sys_rst_in,          // async reset, active high
    input wire logic an_done_in,          // negotiation complete level
    input wire logic mdio_out,            // data driven by device
    input wire logic mdio_oe_out,         // device drive enable
    input wire logic an_restart_out,      // restart pulse
    input wire logic soft_reset_out,      // soft reset running
    input wire logic [15:0] ctrl_word_out, // stored control bits
    input wire logic [15:0] adv_word_out  // stored advertisement bits
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // defaults must be present the first cycle after release
    property p_rst_dflt; $fell(sys_rst_in) |-> ctrl_word_out == 16'h1140 && adv_word_out == 16'h01e1; endproperty
    a_rst_dflt: assert property (p_rst_dflt) else $error("defaults missing after reset");
    // negotiation finishing never touches the advertisement
    property p_adv_hold; $rose(an_done_in) |-> ##1 $stable(adv_word_out) [*3]; endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("advertisement moved on completion");
    property p_restart_pulse; an_restart_out |=> !an_restart_out; endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart longer than one cycle");
    // writes are ignored while the soft reset runs, so no restart then
    property p_restart_srst; an_restart_out |-> !soft_reset_out; endproperty
    a_restart_srst: assert property (p_restart_srst) else $error("restart during soft reset");
    property p_srst_len; $rose(soft_reset_out) |-> ##19 soft_reset_out ##1 !soft_reset_out; endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset not 20 cycles");
    property p_srst_dflt; $fell(soft_reset_out) |-> ctrl_word_out == 16'h1140 && adv_word_out == 16'h01e1; endproperty
    a_srst_dflt: assert property (p_srst_dflt) else $error("soft reset left stale words");
    // second turnaround bit is a driven zero
    property p_ta_zero; $rose(mdio_oe_out) |-> !mdio_out; endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
    // cycles driven so far; 17 link periods of 64 ns make 217 or 218 cycles
    logic [8:0] oe_cnt;
    always @(posedge sys_clk_in or posedge sys_rst_in)
        if (sys_rst_in) oe_cnt <= 9'h000;
        else oe_cnt <= mdio_oe_out ? oe_cnt + 9'h001 : 9'h000;
    property p_drive_len; $fell(mdio_oe_out) |-> oe_cnt >= 9'h0d8 && oe_cnt <= 9'h0db; endproperty
    a_drive_len: assert property (p_drive_len) else $error("read drive length wrong");
endmodule // phy_status_regs_checker

bind phy_status_regs phy_status_regs_checker chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .an_done_in(an_done_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .an_restart_out(an_restart_out),
    .soft_reset_out(soft_reset_out), .ctrl_word_out(ctrl_word_out), .adv_word_out(adv_word_out));

// ### sim/phy_status_regs_tb.sv
`include "phy_status_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module phy_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ID1 = 16'h3c96; // arbitrary value
    localparam logic [5:0] OUI_HI = 6'h2d;  // arbitrary value
    localparam logic [5:0] MODEL = 6'h1e;   // arbitrary value
    localparam logic [3:0] REV = 4'h9;      // arbitrary value
    logic sys_clk_in, sys_rst_in, an_done, rflt, link_ok, jab, mdc, st_d, st_oe;
    wire mdio_out, mdio_oe_out, an_restart_out, soft_reset_out, mdio_line;
    wire [15:0] ctrl_word_out, adv_word_out;
    int err_count, n_compared, n_restart, r0;
    logic [15:0] rd;
    // pulled-up line: whoever enables drives it
    assign mdio_line = mdio_oe_out ? mdio_out : (st_oe ? st_d : 1'b1);
    phy_status_regs #(.OUI_WORD1(ID1), .OUI_WORD2(OUI_HI), .MODEL_CODE(MODEL), .REV_CODE(REV)) dut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .mdc_in(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .an_done_in(an_done), .remote_fault_in(rflt),
        .link_ok_in(link_ok), .jabber_in(jab), .an_restart_out(an_restart_out),
        .soft_reset_out(soft_reset_out), .ctrl_word_out(ctrl_word_out), .adv_word_out(adv_word_out));
    mgmt_station st (.mdc_out(mdc), .drv_out(st_d), .oe_out(st_oe), .mdio_in(mdio_line));
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // restart pulses counted so each write's effect can be seen
    always @(posedge sys_clk_in) if (an_restart_out === 1'b1) n_restart <= n_restart + 1;
    task automatic rd_chk(input string nm, input logic pre, input logic [4:0] ra, input logic [15:0] e);
        st.frame(pre, `OP_RD, 5'h01, ra, 16'h0000, rd);
        `CHK(nm, e, rd)
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        st.frame(1'b0, `OP_WR, 5'h01, ra, d, rd);
        repeat (4) @(posedge sys_clk_in);
    endtask
    // condition levels change just after the edge
    task automatic set_in(input logic a, input logic r, input logic l, input logic j);
        @(posedge sys_clk_in);
        #1 {an_done, rflt, link_ok, jab} = {a, r, l, j};
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        final_report;
    end
    initial begin
        {an_done, rflt, link_ok, jab} = 4'h0;
        sys_rst_in = 1'b1;
        repeat (5) @(posedge sys_clk_in);
        #1 sys_rst_in = 1'b0;
        repeat (5) @(posedge sys_clk_in);
        rd_chk("status", 1'b0, `REG_STAT, 16'h7949);
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk("link_held", 1'b1, `REG_STAT, 16'h7949);
        rd_chk("link_up", 1'b0, `REG_STAT, 16'h794d);
        // one-cycle fault, jabber and link drop must all be caught
        set_in(1'b0, 1'b1, 1'b0, 1'b1);
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk("events", 1'b0, `REG_STAT, 16'h795b);
        rd_chk("cleared", 1'b0, `REG_STAT, 16'h794d);
        set_in(1'b1, 1'b1, 1'b1, 1'b0);
        rd_chk("persist", 1'b0, `REG_STAT, 16'h797d);
        rd_chk("persist2", 1'b0, `REG_STAT, 16'h797d);
        rd_chk("id1", 1'b0, `REG_ID1, ID1);
        rd_chk("id2", 1'b0, `REG_ID2, {OUI_HI, MODEL, REV});
        rd_chk("unmapped", 1'b0, 5'h10, 16'h0000);
        st.frame(1'b0, `OP_RD, 5'h07, `REG_STAT, 16'h0000, rd);
        `CHK("other_addr", 16'hffff, rd)
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        r0 = n_restart;
        wr(`REG_ADV, 16'hffff);
        `CHK("restart", r0 + 1, n_restart)
        rd_chk("adv", 1'b0, `REG_ADV, 16'hadff);
        set_in(1'b1, 1'b0, 1'b1, 1'b0);
        wr(`REG_ADV, 16'h0061);
        `CHK("no_restart", r0 + 1, n_restart)
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        set_in(1'b1, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge sys_clk_in);
        #1;
        `CHK("adv_kept", 16'h0061, adv_word_out)
        // a fault is pending when the soft reset lands, it must be gone after
        set_in(1'b0, 1'b1, 1'b1, 1'b0);
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        wr(`REG_CTRL, 16'h8000);
        #1;
        `CHK("srst_busy", 1'b1, soft_reset_out)
        for (int k = 0; k < 60 && soft_reset_out !== 1'b0; k++) @(posedge sys_clk_in);
        #1;
        `CHK("ctrl_dflt", 16'h1140, ctrl_word_out)
        `CHK("adv_dflt", 16'h01e1, adv_word_out)
        rd_chk("ctrl_rd", 1'b0, `REG_CTRL, 16'h1140);
        rd_chk("status_rst", 1'b0, `REG_STAT, 16'h7949);
        // control bit 9 pulses a restart and is never stored
        r0 = n_restart;
        wr(`REG_CTRL, 16'h1340);
        #1;
        `CHK("ctrl_restart", r0 + 1, n_restart)
        `CHK("ctrl_selfclr", 16'h1140, ctrl_word_out)
        final_report;
    end
endmodule // phy_status_regs_tb
